/* logic/acs_pkg.sv */
package acs_pkg;
  localparam logic [7:0] ACS_OFF_CTL1 = 8'h08;
  localparam logic [7:0] ACS_OFF_SAMPT_INT = 8'h0c;
  localparam logic [7:0] ACS_OFF_SAMPT_EXT = 8'h10;
  localparam logic [7:0] ACS_OFF_STATE = 8'h14;
  localparam logic [7:0] ACS_OFF_RESULT = 8'h18;
  localparam logic [31:0] ACS_RESET_VALUE = 32'h00000000;
  localparam int ACS_BIT_INT_EN = 23;
  localparam int ACS_BIT_SWSTART = 22;
  localparam int ACS_BIT_TRIG_EN = 20;
  localparam int ACS_TSEL_HI = 19;
  localparam int ACS_TSEL_LO = 17;
  localparam int ACS_BIT_ALIGN = 11;
  localparam int ACS_BIT_DMA = 8;
  localparam int ACS_BIT_CALRST = 3;
  localparam int ACS_BIT_CAL = 2;
  localparam int ACS_BIT_CONT = 1;
  localparam int ACS_BIT_ON = 0;
  localparam logic [31:0] ACS_CTL1_MASK = 32'h00de090f;
  localparam logic [31:0] ACS_SAMPT_INT_MASK = 32'h00fc0000;
  localparam logic [31:0] ACS_SAMPT_EXT_MASK = 32'h3fffffff;
  localparam logic [2:0] ACS_TSEL_SOFT = 3'h7;
  localparam logic [2:0] ACS_TSEL_RESV = 3'h3;
  localparam int ACS_STAB_CYCLES = 64;
  localparam int ACS_CALRST_CYCLES = 4;
  localparam int ACS_CAL_CYCLES = 83;
  localparam int ACS_CONV_CYCLES = 13;
  localparam int ACS_CLK_DIV = 4;
  localparam int ACS_CNT_W = 12;
  typedef enum logic [2:0] {
    ACS_OFF = 3'b000,
    ACS_STAB = 3'b001,
    ACS_IDLE = 3'b010,
    ACS_SAMPLE = 3'b011,
    ACS_CONVERT = 3'b100,
    ACS_CALRST = 3'b101,
    ACS_CAL = 3'b110
  } acs_state_t;
endpackage

/* logic/acs_core_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface acs_core_if;
  logic [4:0] chan;
  logic [2:0] sel;
  logic [11:0] half_cycles;
  modport ctl (output chan, output sel, input half_cycles);
  modport lut (input chan, input sel, output half_cycles);
endinterface
`default_nettype wire

/* logic/acs_sample_lut.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_sample_lut
  import acs_pkg::*;
(
  acs_core_if.lut core
);
  // sampling time in half converter cycles, so x.5 stays exact
  always_comb begin
    case (core.sel)
      3'h0: core.half_cycles = 12'h003;
      3'h1: core.half_cycles = 12'h00f;
      3'h2: core.half_cycles = 12'h01b;
      3'h3: core.half_cycles = 12'h039;
      3'h4: core.half_cycles = 12'h053;
      3'h5: core.half_cycles = 12'h06f;
      3'h6: core.half_cycles = 12'h08f;
      3'h7: core.half_cycles = 12'h1df;
      default: core.half_cycles = 12'h003;
    endcase
  end
endmodule // acs_sample_lut
`default_nettype wire

/* logic/acs_top.sv */
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module acs_top
  import acs_pkg::*;
#(
  parameter int STAB_CYCLES = ACS_STAB_CYCLES,
  parameter int CLK_DIV = ACS_CLK_DIV
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [6:0] trig_pin_i,
  input wire logic [4:0] chan_i,
  input wire logic [11:0] adc_data_i,
  output logic adc_power_o,
  output logic adc_sample_o,
  output logic [4:0] adc_chan_o,
  output logic internal_channel_enable_o,
  output logic [15:0] result_o,
  output logic result_valid_o,
  output logic dma_req_o
);
  logic [31:0] ctl1_reg;
  logic [31:0] sampt_int_reg;
  logic [31:0] sampt_ext_reg;
  logic [31:0] rdata_reg;
  logic [15:0] result_reg;
  logic result_valid_reg;
  logic dma_req_reg;
  logic [6:0] trig_s1_reg;
  logic [6:0] trig_s2_reg;
  logic [6:0] trig_s3_reg;
  logic [ACS_CNT_W-1:0] div_cnt_reg;
  logic tick;
  acs_state_t state_reg;
  logic [ACS_CNT_W-1:0] cnt_reg;
  logic [4:0] chan_reg;
  logic start_req;
  logic sw_start;
  logic ext_start;
  logic on_rewrite;
  logic ctl1_wr;
  logic sample_done;
  logic conv_done;
  logic [2:0] tsel;
  logic [6:0] trig_rise;
  acs_core_if core ();

  function automatic logic [2:0] acs_field(input logic [31:0] r, input int lsb);
    acs_field = 3'((r >> lsb) & 32'h7);
  endfunction

  assign tsel = ctl1_reg[ACS_TSEL_HI:ACS_TSEL_LO];
  assign ctl1_wr = wr_i && (addr_i == ACS_OFF_CTL1);

  // converter clock enable derived from mclk
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_cnt_reg <= '0;
    end else if (div_cnt_reg == ACS_CNT_W'(CLK_DIV - 1)) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 1'b1;
    end
  end
  assign tick = (div_cnt_reg == ACS_CNT_W'(CLK_DIV - 1));

  // trigger pins: two-flop sync, then rising edge on synced copies
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trig_s1_reg <= '0;
      trig_s2_reg <= '0;
      trig_s3_reg <= '0;
    end else begin
      trig_s1_reg <= trig_pin_i;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
    end
  end
  assign trig_rise = trig_s2_reg & ~trig_s3_reg;

  always_comb begin
    ext_start = 1'b0;
    if (ctl1_reg[ACS_BIT_TRIG_EN] && tsel != ACS_TSEL_SOFT && tsel != ACS_TSEL_RESV) begin
      ext_start = trig_rise[tsel];
    end
  end
  assign sw_start = ctl1_reg[ACS_BIT_SWSTART] && (tsel == ACS_TSEL_SOFT);
  assign on_rewrite = ctl1_wr && ctl1_reg[ACS_BIT_ON] && wdata_i[ACS_BIT_ON]
    && ((wdata_i & ACS_CTL1_MASK) == ctl1_reg);
  assign start_req = sw_start || ext_start || on_rewrite;

  // sample-time field of the selected channel
  always_comb begin
    core.chan = chan_reg;
    if (chan_reg == 5'h10) begin
      core.sel = acs_field(sampt_int_reg, 18);
    end else if (chan_reg == 5'h11) begin
      core.sel = acs_field(sampt_int_reg, 21);
    end else if (chan_reg < 5'h0a) begin
      core.sel = acs_field(sampt_ext_reg, 3 * int'(chan_reg));
    end else begin
      core.sel = 3'h0;
    end
  end
  acs_sample_lut u_lut (
    .core(core)
  );

  // sample ticks so far, doubled, against the half-cycle count: x.5 rounds up
  assign sample_done = tick && ({cnt_reg, 1'b0} + 13'h002 >= {1'b0, core.half_cycles});
  assign conv_done = tick && (cnt_reg == ACS_CNT_W'(1));

  // converter sequencer
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ACS_OFF;
      cnt_reg <= '0;
      chan_reg <= '0;
    end else if (!ctl1_reg[ACS_BIT_ON]) begin
      state_reg <= ACS_OFF;
      cnt_reg <= '0;
    end else begin
      case (state_reg)
        ACS_OFF: begin
          state_reg <= ACS_STAB;
          cnt_reg <= ACS_CNT_W'(STAB_CYCLES);
        end
        ACS_STAB: begin
          if (tick) begin
            if (cnt_reg <= ACS_CNT_W'(1)) begin
              state_reg <= ACS_IDLE;
            end else begin
              cnt_reg <= cnt_reg - 1'b1;
            end
          end
        end
        ACS_IDLE: begin
          if (ctl1_reg[ACS_BIT_CALRST]) begin
            state_reg <= ACS_CALRST;
            cnt_reg <= ACS_CNT_W'(ACS_CALRST_CYCLES);
          end else if (ctl1_reg[ACS_BIT_CAL]) begin
            state_reg <= ACS_CAL;
            cnt_reg <= ACS_CNT_W'(ACS_CAL_CYCLES);
          end else if (start_req) begin
            state_reg <= ACS_SAMPLE;
            chan_reg <= chan_i;
            cnt_reg <= '0;
          end
        end
        ACS_SAMPLE: begin
          // counts sample ticks up from zero for the latched channel
          if (sample_done) begin
            state_reg <= ACS_CONVERT;
            cnt_reg <= ACS_CNT_W'(ACS_CONV_CYCLES);
          end else if (tick) begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ACS_CONVERT: begin
          if (conv_done) begin
            if (ctl1_reg[ACS_BIT_CONT]) begin
              state_reg <= ACS_SAMPLE;
              cnt_reg <= '0;
            end else begin
              state_reg <= ACS_IDLE;
            end
          end else if (tick) begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        ACS_CALRST, ACS_CAL: begin
          if (tick) begin
            if (cnt_reg <= ACS_CNT_W'(1)) begin
              state_reg <= ACS_IDLE;
            end else begin
              cnt_reg <= cnt_reg - 1'b1;
            end
          end
        end
        default: begin
          state_reg <= ACS_OFF;
        end
      endcase
    end
  end

  // control register; hardware clears win over a simultaneous software write
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl1_reg <= ACS_RESET_VALUE;
    end else begin
      if (ctl1_wr) begin
        ctl1_reg <= wdata_i & ACS_CTL1_MASK;
      end
      if (state_reg == ACS_IDLE && sw_start && ctl1_reg[ACS_BIT_ON] && !ctl1_reg[ACS_BIT_CALRST]
          && !ctl1_reg[ACS_BIT_CAL]) begin
        ctl1_reg[ACS_BIT_SWSTART] <= 1'b0;
      end
      if (state_reg == ACS_CALRST && tick && cnt_reg <= ACS_CNT_W'(1)) begin
        ctl1_reg[ACS_BIT_CALRST] <= 1'b0;
      end
      if (state_reg == ACS_CAL && tick && cnt_reg <= ACS_CNT_W'(1)) begin
        ctl1_reg[ACS_BIT_CAL] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sampt_int_reg <= ACS_RESET_VALUE;
      sampt_ext_reg <= ACS_RESET_VALUE;
    end else if (wr_i) begin
      if (addr_i == ACS_OFF_SAMPT_INT) begin
        sampt_int_reg <= wdata_i & ACS_SAMPT_INT_MASK;
      end
      if (addr_i == ACS_OFF_SAMPT_EXT) begin
        sampt_ext_reg <= wdata_i & ACS_SAMPT_EXT_MASK;
      end
    end
  end

  // result capture, alignment and dma request
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_reg <= '0;
      result_valid_reg <= 1'b0;
      dma_req_reg <= 1'b0;
    end else begin
      result_valid_reg <= 1'b0;
      dma_req_reg <= 1'b0;
      if (state_reg == ACS_CONVERT && conv_done) begin
        result_valid_reg <= 1'b1;
        dma_req_reg <= ctl1_reg[ACS_BIT_DMA];
        if (ctl1_reg[ACS_BIT_ALIGN]) begin
          result_reg <= {adc_data_i, 4'h0};
        end else begin
          result_reg <= {4'h0, adc_data_i};
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_reg <= '0;
    end else if (rd_i) begin
      case (addr_i)
        ACS_OFF_CTL1: rdata_reg <= ctl1_reg;
        ACS_OFF_SAMPT_INT: rdata_reg <= sampt_int_reg;
        ACS_OFF_SAMPT_EXT: rdata_reg <= sampt_ext_reg;
        ACS_OFF_STATE: rdata_reg <= {24'h0, chan_reg, state_reg};
        ACS_OFF_RESULT: rdata_reg <= {16'h0, result_reg};
        default: rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  assign rdata_o = rdata_reg;
  assign adc_power_o = ctl1_reg[ACS_BIT_ON];
  assign adc_sample_o = (state_reg == ACS_SAMPLE);
  assign adc_chan_o = chan_reg;
  assign internal_channel_enable_o = ctl1_reg[ACS_BIT_INT_EN];
  assign result_o = result_reg;
  assign result_valid_o = result_valid_reg;
  assign dma_req_o = dma_req_reg;
endmodule // acs_top
`default_nettype wire

/* verification/acs_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_core_model (
  input wire logic clk_i,
  input wire logic power_i,
  input wire logic [11:0] val_i,
  input wire logic [6:0] fire_i,
  output logic [11:0] data_o,
  output logic [6:0] trig_o
);
  logic [11:0] junk_reg = 12'h000;
  logic [2:0] hold_reg = 3'h0;
  logic [6:0] trig_reg = 7'h00;
  assign trig_o = trig_reg;
  // a powered-down core gives nothing useful, so its output keeps moving
  always_ff @(posedge clk_i) begin
    junk_reg <= junk_reg + 12'h5a5;
  end
  assign data_o = power_i ? val_i : junk_reg;
  // pulse held long enough to pass the two-flop synchroniser
  always_ff @(posedge clk_i) begin
    if (fire_i != 7'h00) begin
      trig_reg <= fire_i;
      hold_reg <= 3'h4;
    end else if (hold_reg != 3'h0) begin
      hold_reg <= hold_reg - 3'h1;
    end else begin
      trig_reg <= 7'h00;
    end
  end
endmodule // acs_core_model
`default_nettype wire

/* verification/acs_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_top_chk
  import acs_pkg::*;
#(
  parameter int STAB_CYCLES = ACS_STAB_CYCLES,
  parameter int CLK_DIV = ACS_CLK_DIV
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [6:0] trig_pin_i,
  input wire logic [4:0] chan_i,
  input wire logic [11:0] adc_data_i,
  input wire logic adc_power_o,
  input wire logic adc_sample_o,
  input wire logic [4:0] adc_chan_o,
  input wire logic internal_channel_enable_o,
  input wire logic [15:0] result_o,
  input wire logic result_valid_o,
  input wire logic dma_req_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  AST_INT_EN:
  assert property (wr_i && addr_i == ACS_OFF_CTL1 |=>
    internal_channel_enable_o == $past(wdata_i[ACS_BIT_INT_EN])) else $error("int enable");
  AST_POWER:
  assert property (wr_i && addr_i == ACS_OFF_CTL1 |=>
    adc_power_o == $past(wdata_i[ACS_BIT_ON])) else $error("power level");
  AST_OFF_IDLE:
  assert property (!adc_power_o |=> !adc_sample_o) else $error("sampling while off");
  // off, two stabilisation ticks at least, then idle before any sample
  AST_STAB:
  assert property ($rose(adc_power_o) |-> !adc_sample_o [*4]) else $error("early sample");
  AST_DMA:
  assert property (dma_req_o |-> result_valid_o) else $error("dma without result");
  AST_PULSE:
  assert property (result_valid_o |=> !result_valid_o) else $error("valid too long");
  AST_RD_IDLE:
  assert property (!rd_i |=> rdata_o == 32'h0) else $error("stray read data");
  AST_INT_RSV:
  assert property (rd_i && addr_i == ACS_OFF_SAMPT_INT |=>
    (rdata_o & ~ACS_SAMPT_INT_MASK) == 32'h0) else $error("internal reserved");
  AST_EXT_RSV:
  assert property (rd_i && addr_i == ACS_OFF_SAMPT_EXT |=>
    (rdata_o & ~ACS_SAMPT_EXT_MASK) == 32'h0) else $error("external reserved");
  cover property (dma_req_o);
  cover property ($fell(adc_sample_o));
  cover property ($rose(adc_power_o));
endmodule // acs_top_chk
bind acs_top acs_top_chk #(.STAB_CYCLES(STAB_CYCLES), .CLK_DIV(CLK_DIV)) i_acs_top_chk (
  .mclk_i(mclk_i),
  .resetn_i(resetn_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .trig_pin_i(trig_pin_i),
  .chan_i(chan_i),
  .adc_data_i(adc_data_i),
  .adc_power_o(adc_power_o),
  .adc_sample_o(adc_sample_o),
  .adc_chan_o(adc_chan_o),
  .internal_channel_enable_o(internal_channel_enable_o),
  .result_o(result_o),
  .result_valid_o(result_valid_o),
  .dma_req_o(dma_req_o)
);
`default_nettype wire

/* verification/acs_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_top_tb
  import acs_pkg::*;
;
  logic mclk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, rd_q = 0;
  logic [7:0] addr_i = 0;
  logic [31:0] wdata_i = 0, rdata_o, last_rd, c;
  logic [6:0] trig_pin_i, fire = 0;
  logic [4:0] chan_i = 0, adc_chan_o;
  logic [11:0] adc_data_i, val = 0;
  logic adc_power_o, adc_sample_o, internal_channel_enable_o, result_valid_o, dma_req_o;
  logic [15:0] result_o;
  logic [63:0] e;
  logic [21:0] r;
  logic [63:0] q_rd[$];
  logic [21:0] q_res[$];
  int q_len[$];
  int fails = 0, n_compared = 0, seed = 93479, cyc = 0, slen = 0, k;
  int lens[8] = '{2, 8, 14, 29, 42, 56, 72, 240};
  localparam logic [31:0] BASE = 32'h008e0001, SW = 32'h00400000;
  acs_top #(.STAB_CYCLES(2), .CLK_DIV(1)) i_acs_top (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .trig_pin_i(trig_pin_i),
    .chan_i(chan_i),
    .adc_data_i(adc_data_i),
    .adc_power_o(adc_power_o),
    .adc_sample_o(adc_sample_o),
    .adc_chan_o(adc_chan_o),
    .internal_channel_enable_o(internal_channel_enable_o),
    .result_o(result_o),
    .result_valid_o(result_valid_o),
    .dma_req_o(dma_req_o)
  );
  acs_core_model i_acs_core_model (.clk_i(mclk_i), .power_i(adc_power_o), .val_i(val),
    .fire_i(fire), .data_o(adc_data_i), .trig_o(trig_pin_i));
  always #10 mclk_i = ~mclk_i;
  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      fails++;
      $display("FAIL %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic chk_rd(logic [31:0] ex, logic [31:0] got);
    chk("rdata", ex, got);
  endtask
  task automatic chk_res(logic [31:0] ex, logic [31:0] got);
    chk("result", ex, got);
  endtask
  task automatic chk_len(logic [31:0] ex, logic [31:0] got);
    chk("sample len", ex, got);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] ex);
    q_rd.push_back({m, ex});
    @(posedge mclk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 0;
  endtask
  task automatic conv(logic [31:0] ctl, int len);
    logic [11:0] v;
    v = 12'($random(seed));
    val <= v;
    q_res.push_back({chan_i, ctl[ACS_BIT_DMA], ctl[ACS_BIT_ALIGN] ? {v, 4'h0} : {4'h0, v}});
    q_len.push_back(len);
  endtask
  task automatic settle();
    for (int i = 0; i < 600 && (q_res.size() + q_len.size()) > 0; i++) @(posedge mclk_i);
    repeat (30) @(posedge mclk_i);
  endtask
  task automatic fire_pins(logic [6:0] m);
    @(posedge mclk_i);
    fire <= m;
    @(posedge mclk_i);
    fire <= 0;
    settle();
  endtask
  task automatic poll(int b);
    for (int i = 0; i < 100; i++) begin
      rd(ACS_OFF_CTL1, 0, 0);
      // the monitor takes the read data at the next edge; look one edge later
      repeat (2) @(posedge mclk_i);
      if (!last_rd[b]) break;
    end
    rd(ACS_OFF_CTL1, 32'h1 << b, 0);
  endtask
  task automatic st(logic [4:0] ch, logic [7:0] a, logic [31:0] d, int len);
    chan_i <= ch;
    wr(a, d);
    conv(BASE, len);
    wr(ACS_OFF_CTL1, BASE | SW);
    settle();
  endtask
  task automatic summarize();
    chk("leftover", 0, 32'(q_res.size() + q_len.size()));
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    rd_q <= rd_i;
    cyc++;
    if (rd_q) begin
      last_rd = rdata_o;
      e = q_rd.pop_front();
      chk_rd(e[31:0], rdata_o & e[63:32]);
    end
    if (result_valid_o === 1'b1) begin
      if (q_res.size() == 0) chk("extra result", 0, 1);
      else begin
        r = q_res.pop_front();
        chk_res(32'(r), 32'({adc_chan_o, dma_req_o, result_o}));
      end
    end
    if (adc_sample_o === 1'b1) slen++;
    else if (slen > 0) begin
      if (q_len.size() > 0) chk_len(q_len.pop_front(), slen);
      slen = 0;
    end
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1;
    rd(ACS_OFF_CTL1, '1, 0);
    rd(ACS_OFF_SAMPT_INT, '1, 0);
    rd(8'h04, '1, 0);
    wr(ACS_OFF_SAMPT_INT, '1);
    wr(ACS_OFF_SAMPT_EXT, '1);
    rd(ACS_OFF_SAMPT_INT, '1, ACS_SAMPT_INT_MASK);
    rd(ACS_OFF_SAMPT_EXT, '1, ACS_SAMPT_EXT_MASK);
    wr(ACS_OFF_CTL1, 32'h1);
    repeat (10) @(posedge mclk_i);
    for (k = 0; k < 8; k++) st(0, ACS_OFF_SAMPT_EXT, 32'(k), lens[k]);
    st(9, ACS_OFF_SAMPT_EXT, 32'h5 << 27, 56);
    st(16, ACS_OFF_SAMPT_INT, 32'h3 << 18, 29);
    st(17, ACS_OFF_SAMPT_INT, 32'h6 << 21, 72);
    st(0, ACS_OFF_SAMPT_EXT, 0, 2);
    for (k = 0; k < 4; k++) begin
      c = BASE | (k[0] ? 32'h800 : 0) | (k[1] ? 32'h100 : 0);
      conv(c, 2);
      wr(ACS_OFF_CTL1, c | SW);
      settle();
      rd(ACS_OFF_CTL1, '1, c);
    end
    conv(c, 2);
    wr(ACS_OFF_CTL1, c);
    settle();
    wr(ACS_OFF_CTL1, 32'h00400001);
    settle();
    for (k = 0; k < 7; k++) if (k != 3) begin
      c = 32'h00100001 | (32'(k) << 17);
      wr(ACS_OFF_CTL1, c);
      fire_pins(~(7'h1 << k));
      conv(c, 2);
      fire_pins(7'h1 << k);
    end
    wr(ACS_OFF_CTL1, 32'h00160001);
    fire_pins(7'h7f);
    wr(ACS_OFF_CTL1, 32'h00000001);
    fire_pins(7'h7f);
    wr(ACS_OFF_CTL1, 32'h9);
    poll(ACS_BIT_CALRST);
    wr(ACS_OFF_CTL1, 32'h5);
    poll(ACS_BIT_CAL);
    // the core holds one value, so every pass of the run gives the same result
    conv(32'h3, 2);
    for (k = 0; k < 2; k++) begin
      q_res.push_back(q_res[$]);
      q_len.push_back(2);
    end
    wr(ACS_OFF_CTL1, 32'h000e0003 | SW);
    for (k = 0; k < 600 && q_res.size() > 0; k++) @(posedge mclk_i);
    wr(ACS_OFF_CTL1, 0);
    settle();
    summarize();
  end
endmodule // acs_top_tb
`default_nettype wire
